// [logic/ecod_decoder.sv]
// Overview of operation
// (RULE1) Opcode 9F copies index into accumulator in 2 cycles, flags untouched.
// (RULE2) Opcode 8F clears interrupt mask, stops CPU clock until interrupt; 2 cycles.
// (RULE3) High nibble classifies: bit, branch, read-modify-write, control, register/memory.
// (RULE4) Bit-test-and-branch fetches direct address byte then displacement byte.
// (RULE5) 16-bit indexed offset: high byte then low, address is offset plus index.
// (RULE6) Full address mode fetches address high byte then low byte.
// (RULE7) 8-bit indexed offset: one byte added to index gives address.
// (RULE8) Plain indexed: index is the address, no operand bytes.
// (RULE9) Relative branch fetches one displacement byte, applied when taken.
// (RULE10) Operand field is zero, one or two bytes, set by the mode.
// (RULE11) Column is opcode high digit, row low digit; cell gives mode and length.
// (RULE12) Taken displacement is signed, added to next instruction address.
module ecod_decoder
    import ecod_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] fetch_data,
    input wire logic fetch_valid,
    input wire logic [7:0] index_reg,
    input wire logic [7:0] acc_in,
    input wire logic [15:0] pc_in,
    input wire logic branch_taken,
    input wire logic irq_pending,
    output logic fetch_req,
    output logic [7:0] cur_opcode,
    output ecod_group_e cur_group,
    output ecod_mode_e cur_mode,
    output logic [1:0] cur_length,
    output logic [15:0] eff_addr,
    output logic [7:0] literal_byte,
    output logic [15:0] branch_target,
    output logic branch_load,
    output logic exec_valid,
    output logic [7:0] acc_out,
    output logic acc_load,
    output logic clear_imask,
    output logic flags_hold,
    output logic cpu_clk_stop
);
    // --------------------------------------------------------
    // Declarations
    // --------------------------------------------------------
    ecod_state_e state;
    ecod_group_e dec_group;
    ecod_mode_e dec_mode;
    logic [1:0] dec_bytes;
    logic dec_bit_branch;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [15:0] next_eff;
    logic [15:0] next_target;
    logic [7:0] disp;
    logic [3:0] cyc;
    logic exec_last;
    logic dec_is_branch;

    ecod_classify u_classify (
        .opcode(cur_opcode),
        .group(dec_group),
        .mode(dec_mode),
        .operand_bytes(dec_bytes),
        .bit_branch(dec_bit_branch)
    );

    // --------------------------------------------------------
    // Shared opcode tests
    // --------------------------------------------------------
    function automatic logic is_copy_op(input logic [7:0] op);
        return op == ECOD_OP_COPY_X_TO_A;
    endfunction

    function automatic logic is_wait_op(input logic [7:0] op);
        return op == ECOD_OP_WAIT;
    endfunction

    // Last execute cycle; every end-of-instruction strobe keys off it
    assign exec_last = (state == ECOD_ST_EXEC) && (cyc == 4'h1);
    assign dec_is_branch = (dec_mode == relative_mode) || dec_bit_branch;

    // --------------------------------------------------------
    // Address and target forming
    // --------------------------------------------------------
    always_comb begin
        unique case (cur_mode)
            full_address_mode: next_eff = {byte1, byte2}; // RULE6
            indexed_long_offset_mode: next_eff = 16'({byte1, byte2} + {8'h00, index_reg}); // RULE5
            indexed_short_offset_mode: next_eff = 16'({8'h00, byte1} + {8'h00, index_reg}); // RULE7
            indexed_plain_mode: next_eff = {8'h00, index_reg}; // RULE8
            direct_mode, literal_operand_mode: next_eff = {8'h00, byte1};
            default: next_eff = ECOD_RESET_WORD;
        endcase
        // Bit-test branches carry the displacement in the second byte
        disp = dec_bit_branch ? byte2 : byte1;
        // pc_in points past the last operand byte: the following instruction
        next_target = 16'(pc_in + {{8{disp[7]}}, disp}); // RULE12
    end

    // --------------------------------------------------------
    // Fetch sequencer
    // --------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ECOD_ST_OPCODE;
        end else begin
            unique case (state)
                ECOD_ST_OPCODE: if (fetch_valid) state <= ECOD_ST_BYTE1;
                ECOD_ST_BYTE1: begin
                    // Decode of the latched opcode settles here; length picks the path
                    if (dec_bytes == 2'h0) state <= ECOD_ST_EXEC; // RULE10
                    else if (fetch_valid && dec_bytes == 2'h1) state <= ECOD_ST_EXEC;
                    else if (fetch_valid) state <= ECOD_ST_BYTE2;
                end
                ECOD_ST_BYTE2: if (fetch_valid) state <= ECOD_ST_EXEC;
                ECOD_ST_EXEC: begin
                    if (cyc > 4'h1) state <= ECOD_ST_EXEC;
                    else if (is_wait_op(cur_opcode)) state <= ECOD_ST_WAIT; // RULE2
                    else state <= ECOD_ST_OPCODE;
                end
                ECOD_ST_WAIT: if (irq_pending) state <= ECOD_ST_OPCODE;
                default: state <= ECOD_ST_OPCODE;
            endcase
        end
    end

    // --------------------------------------------------------
    // Opcode and operand capture
    // --------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur_opcode <= ECOD_RESET_BYTE;
            byte1 <= ECOD_RESET_BYTE;
            byte2 <= ECOD_RESET_BYTE;
        end else begin
            if (state == ECOD_ST_OPCODE && fetch_valid) cur_opcode <= fetch_data;
            // First operand byte is the high byte in full address and 16-bit indexed forms, the direct address in bit-test branches
            if (state == ECOD_ST_BYTE1 && fetch_valid && dec_bytes != 2'h0) byte1 <= fetch_data;
            if (state == ECOD_ST_BYTE2 && fetch_valid) byte2 <= fetch_data; // RULE4
        end
    end

    // --------------------------------------------------------
    // Cycle count of execute phase
    // --------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cyc <= 4'h0;
        end else if (state != ECOD_ST_EXEC) begin
            // Both documented inherent ops take 2 cycles; others use the default
            if (is_copy_op(cur_opcode)) cyc <= ECOD_CYC_COPY_X_TO_A; // RULE1
            else if (is_wait_op(cur_opcode)) cyc <= ECOD_CYC_WAIT; // RULE2
            else cyc <= ECOD_CYC_DEFAULT;
        end else if (cyc != 4'h0) begin
            cyc <= cyc - 4'h1;
        end
    end

    // --------------------------------------------------------
    // Fetch request
    // --------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fetch_req <= 1'b0;
        end else begin
            // Lags the state by one edge; the far side offers only while it is high
            fetch_req <= (state == ECOD_ST_OPCODE) || (state == ECOD_ST_BYTE2)
                || (state == ECOD_ST_BYTE1 && dec_bytes != 2'h0);
        end
    end

    // --------------------------------------------------------
    // Decode and address outputs
    // --------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur_group <= ECOD_GRP_BIT;
            cur_mode <= no_operand_mode;
            cur_length <= 2'h0;
            eff_addr <= ECOD_RESET_WORD;
            literal_byte <= ECOD_RESET_BYTE;
        end else begin
            cur_group <= dec_group; // RULE3
            cur_mode <= dec_mode;
            cur_length <= dec_bytes;
            eff_addr <= next_eff;
            literal_byte <= byte1;
        end
    end

    // --------------------------------------------------------
    // Branch outputs
    // --------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            branch_target <= ECOD_RESET_WORD;
            branch_load <= 1'b0;
        end else begin
            branch_target <= next_target;
            // Taken branch loads the pc once, at the end of execute
            branch_load <= exec_last && branch_taken && dec_is_branch; // RULE9
        end
    end

    // --------------------------------------------------------
    // Execute strobe and accumulator copy
    // --------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            exec_valid <= 1'b0;
            acc_out <= ECOD_RESET_BYTE;
            acc_load <= 1'b0;
            flags_hold <= 1'b0;
        end else begin
            exec_valid <= exec_last;
            acc_out <= index_reg;
            acc_load <= exec_last && is_copy_op(cur_opcode); // RULE1
            flags_hold <= (state == ECOD_ST_EXEC) && is_copy_op(cur_opcode); // RULE1
        end
    end

    // --------------------------------------------------------
    // Wait control
    // --------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clear_imask <= 1'b0;
            cpu_clk_stop <= 1'b0;
        end else begin
            clear_imask <= exec_last && is_wait_op(cur_opcode); // RULE2
            // Clock stays stopped until an interrupt is pending
            cpu_clk_stop <= (state == ECOD_ST_WAIT) && !irq_pending; // RULE2
        end
    end
endmodule

// [logic/ecod_pkg.sv]
package ecod_pkg;
    // ------------------------------------------------------------
    // Opcode groups by high nibble
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ECOD_GRP_BIT = 3'h0,
        ECOD_GRP_BRANCH = 3'h1,
        ECOD_GRP_RMW = 3'h2,
        ECOD_GRP_CONTROL = 3'h3,
        ECOD_GRP_REGMEM = 3'h4
    } ecod_group_e;

    // ------------------------------------------------------------
    // Addressing modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        no_operand_mode = 3'h0,
        literal_operand_mode = 3'h1,
        direct_mode = 3'h2,
        full_address_mode = 3'h3,
        indexed_long_offset_mode = 3'h4,
        indexed_short_offset_mode = 3'h5,
        indexed_plain_mode = 3'h6,
        relative_mode = 3'h7
    } ecod_mode_e;

    // ------------------------------------------------------------
    // Fetch sequencer states, Gray along the usual path
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ECOD_ST_OPCODE = 3'h0,
        ECOD_ST_BYTE1 = 3'h1,
        ECOD_ST_BYTE2 = 3'h3,
        ECOD_ST_EXEC = 3'h2,
        ECOD_ST_WAIT = 3'h6
    } ecod_state_e;

    localparam logic [7:0] ECOD_OP_COPY_X_TO_A = 8'h9F;
    localparam logic [7:0] ECOD_OP_WAIT = 8'h8F;
    localparam logic [3:0] ECOD_CYC_COPY_X_TO_A = 4'h2;
    localparam logic [3:0] ECOD_CYC_WAIT = 4'h2;
    localparam logic [3:0] ECOD_CYC_DEFAULT = 4'h2;
    localparam logic [7:0] ECOD_RESET_BYTE = 8'h00;
    localparam logic [15:0] ECOD_RESET_WORD = 16'h0000;
    localparam logic [1:0] ECOD_IMASK_ON_RESET = 2'h1;
endpackage

// [logic/ecod_classify.sv]
module ecod_classify
    import ecod_pkg::*;
(
    input wire logic [7:0] opcode,
    output ecod_group_e group,
    output ecod_mode_e mode,
    output logic [1:0] operand_bytes,
    output logic bit_branch
);
    // --------------------------------------------------------
    // Map column decode
    // --------------------------------------------------------
    always_comb begin
        bit_branch = 1'b0;
        unique case (opcode[7:4])
            4'h0, 4'h1: group = ECOD_GRP_BIT; // RULE3
            4'h2: group = ECOD_GRP_BRANCH;
            4'h3, 4'h4, 4'h5, 4'h6, 4'h7: group = ECOD_GRP_RMW;
            4'h8, 4'h9: group = ECOD_GRP_CONTROL;
            default: group = ECOD_GRP_REGMEM;
        endcase
        unique case (opcode[7:4]) // RULE11
            4'h0: begin
                mode = direct_mode;
                operand_bytes = 2'h2; // RULE4
                bit_branch = 1'b1;
            end
            4'h1, 4'h3, 4'hB: begin
                mode = direct_mode;
                operand_bytes = 2'h1;
            end
            4'h2: begin
                mode = relative_mode;
                operand_bytes = 2'h1; // RULE9
            end
            4'h6, 4'hE: begin
                mode = indexed_short_offset_mode;
                operand_bytes = 2'h1; // RULE7
            end
            4'h7, 4'hF: begin
                mode = indexed_plain_mode;
                operand_bytes = 2'h0; // RULE8
            end
            4'hA: begin
                // Row D of this column is a relative call
                mode = (opcode[3:0] == 4'hD) ? relative_mode : literal_operand_mode;
                operand_bytes = 2'h1;
            end
            4'hC: begin
                mode = full_address_mode;
                operand_bytes = 2'h2; // RULE6
            end
            4'hD: begin
                mode = indexed_long_offset_mode;
                operand_bytes = 2'h2; // RULE5
            end
            default: begin
                mode = no_operand_mode;
                operand_bytes = 2'h0;
            end
        endcase
    end
endmodule

// [verif/ecod_chk.sv]
module ecod_chk
    import ecod_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] index_reg,
    input wire logic irq_pending,
    input wire logic fetch_req,
    input wire logic [7:0] cur_opcode,
    input ecod_group_e cur_group,
    input ecod_mode_e cur_mode,
    input wire logic [1:0] cur_length,
    input wire logic [15:0] eff_addr,
    input wire logic exec_valid,
    input wire logic acc_load,
    input wire logic clear_imask,
    input wire logic flags_hold,
    input wire logic cpu_clk_stop
);
    // ----
    // Column tables
    // ----
    function automatic logic [2:0] grp(input logic [3:0] h);
        return (h < 4'h2) ? 3'h0 : (h == 4'h2) ? 3'h1 : (h < 4'h8) ? 3'h2 :
            (h < 4'hA) ? 3'h3 : 3'h4;
    endfunction
    function automatic logic [1:0] len(input logic [3:0] h);
        return (h inside {4'h0, 4'hC, 4'hD}) ? 2'h2 :
            (h inside {4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hF}) ? 2'h0 : 2'h1;
    endfunction
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_stop;
        clear_imask ##1 cpu_clk_stop;
    endsequence
    sequence s_wake;
        ##[1:4] !cpu_clk_stop;
    endsequence
    group_map_a: assert property (exec_valid |-> cur_group == grp(cur_opcode[7:4]))
        else $error("group does not follow column");
    op_length_a: assert property (exec_valid |-> cur_length == len(cur_opcode[7:4]))
        else $error("operand length does not follow column");
    copy_op_a: assert property (acc_load |-> exec_valid && cur_opcode == 8'h9F)
        else $error("accumulator load on wrong opcode");
    flags_kept_a: assert property (acc_load |-> $past(flags_hold))
        else $error("flags not held during copy");
    imask_op_a: assert property (clear_imask |-> exec_valid && cur_opcode == 8'h8F)
        else $error("mask clear on wrong opcode");
    clk_stop_a: assert property (clear_imask && !irq_pending |-> s_stop)
        else $error("clock not stopped after wait");
    wake_up_a: assert property (cpu_clk_stop && irq_pending |-> s_wake)
        else $error("wait not ended by interrupt");
    no_fetch_a: assert property (cpu_clk_stop && !irq_pending |-> !fetch_req)
        else $error("fetch while clock stopped");
    plain_idx_a: assert property (exec_valid && cur_mode == indexed_plain_mode |->
        eff_addr == {8'h00, index_reg})
        else $error("plain indexed address wrong");
endmodule
bind ecod_decoder ecod_chk chk (.clk, .sys_rst, .index_reg, .irq_pending, .fetch_req,
    .cur_opcode, .cur_group, .cur_mode, .cur_length, .eff_addr, .exec_valid, .acc_load,
    .clear_imask, .flags_hold, .cpu_clk_stop);

// [verif/ecod_mem.sv]
module ecod_mem (
    input wire logic clk,
    input wire logic fetch_req,
    input wire logic slow,
    output logic [7:0] fetch_data,
    output logic fetch_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] byte_q[$];
    logic tick = 1'b0;
    initial fetch_valid = 1'b0;
    initial fetch_data = 8'h00;
    // ----
    // Offer bytes only while asked; idle bus toggles so stale data never matches
    // ----
    always @(posedge clk) if (fetch_valid && fetch_req) void'(byte_q.pop_front());
    always @(negedge clk) begin
        tick = ~tick;
        fetch_valid = fetch_req && byte_q.size() > 0 && !(slow && tick);
        fetch_data = fetch_valid ? byte_q[0] : ~fetch_data;
    end
endmodule

// [verif/ecod_decoder_bench.sv]
module ecod_decoder_bench
    import ecod_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    `define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
        $display("wrong value %s exp %0h got %0h", n, (e), (s)); end end
    logic clk, sys_rst, fetch_valid, branch_taken, irq_pending, slow;
    logic [7:0] fetch_data, index_reg, acc_in, cur_opcode, literal_byte, acc_out;
    logic [15:0] pc_in, eff_addr, branch_target, lf;
    logic fetch_req, branch_load, exec_valid, acc_load, clear_imask, flags_hold, cpu_clk_stop;
    logic [1:0] cur_length;
    ecod_group_e cur_group;
    ecod_mode_e cur_mode;
    int err_total, checked, k;
    logic [7:0] corner [9] = '{8'h00, 8'h20, 8'hAD, 8'hC7, 8'hD2, 8'hEF, 8'hF0, 8'hA6, 8'h9F};
    ecod_decoder dut (.clk, .sys_rst, .fetch_data, .fetch_valid, .index_reg, .acc_in, .pc_in,
        .branch_taken, .irq_pending, .fetch_req, .cur_opcode, .cur_group, .cur_mode,
        .cur_length, .eff_addr, .literal_byte, .branch_target, .branch_load, .exec_valid,
        .acc_out, .acc_load, .clear_imask, .flags_hold, .cpu_clk_stop);
    ecod_mem mem (.clk, .fetch_req, .slow, .fetch_data, .fetch_valid);
    // ----
    // Expectations
    // ----
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic ecod_mode_e mode_of(input logic [7:0] op);
        case (op[7:4])
            4'h2: return relative_mode;
            4'h4, 4'h5, 4'h8, 4'h9: return no_operand_mode;
            4'h6, 4'hE: return indexed_short_offset_mode;
            4'h7, 4'hF: return indexed_plain_mode;
            4'hA: return (op[3:0] == 4'hD) ? relative_mode : literal_operand_mode;
            4'hC: return full_address_mode;
            4'hD: return indexed_long_offset_mode;
            default: return direct_mode;
        endcase
    endfunction
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
        ecod_mode_e m;
        logic [1:0] n;
        logic [7:0] d;
        logic [15:0] ea;
        int i;
        logic br;
        m = mode_of(op);
        br = (m == relative_mode) || (op[7:4] == 4'h0);
        n = (m inside {no_operand_mode, indexed_plain_mode}) ? 2'h0 :
            (m inside {full_address_mode, indexed_long_offset_mode} || op[7:4] == 4'h0) ?
            2'h2 : 2'h1;
        d = (op[7:4] == 4'h0) ? b2 : b1;
        case (m)
            full_address_mode: ea = {b1, b2};
            indexed_long_offset_mode: ea = {b1, b2} + {8'h00, index_reg};
            indexed_short_offset_mode: ea = {8'h00, b1} + {8'h00, index_reg};
            indexed_plain_mode: ea = {8'h00, index_reg};
            default: ea = {8'h00, b1};
        endcase
        mem.byte_q.push_back(op);
        if (n > 2'h0)
            mem.byte_q.push_back(b1);
        if (n > 2'h1)
            mem.byte_q.push_back(b2);
        for (i = 0; i < 50 && exec_valid !== 1'b1; i++)
            @(negedge clk);
        if (i == 50) begin
            err_total++;
            conclude();
        end
        `CHK("opcode", op, cur_opcode)
        `CHK("mode", m, cur_mode)
        `CHK("length", n, cur_length)
        if (n > 2'h0)
            `CHK("first byte", b1, literal_byte)
        if (!(m inside {relative_mode, no_operand_mode, literal_operand_mode}))
            `CHK("address", ea, eff_addr)
        if (br)
            `CHK("target", pc_in + {{8{d[7]}}, d}, branch_target)
        `CHK("branch load", branch_taken & br, branch_load)
        `CHK("acc load", op == 8'h9F, acc_load)
        `CHK("mask clear", op == 8'h8F, clear_imask)
        if (op == 8'h9F)
            `CHK("acc out", index_reg, acc_out)
        @(negedge clk);
    endtask
    // ----
    // Stimulus
    // ----
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {sys_rst, index_reg, acc_in, pc_in} = {1'b1, 8'h00, 8'h00, 16'h0000};
        {branch_taken, irq_pending, slow, err_total, checked} = '0;
        lf = 16'h9E29;
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        {index_reg, pc_in, branch_taken} = {8'hFF, 16'hFFF0, 1'b1};
        foreach (corner[j])
            run(corner[j], 8'hFF, 8'h80);
        run(ECOD_OP_WAIT, 8'h00, 8'h00);
        repeat (3) @(negedge clk);
        `CHK("clock stop", 1'b1, cpu_clk_stop)
        `CHK("fetch in wait", 1'b0, fetch_req)
        irq_pending = 1'b1;
        for (k = 0; k < 20 && cpu_clk_stop !== 1'b0; k++)
            @(negedge clk);
        if (k == 20) begin
            err_total++;
            conclude();
        end
        `CHK("clock stop", 1'b0, cpu_clk_stop)
        irq_pending = 1'b0;
        for (k = 0; k < 80; k++) begin
            lf = nxt(lf);
            {index_reg, acc_in} = lf;
            lf = nxt(lf);
            {pc_in, branch_taken, slow} = {lf, lf[3], lf[9]};
            lf = nxt(lf);
            run((lf[15:8] == 8'h8F) ? 8'h9F : lf[15:8], lf[7:0], lf[11:4]);
        end
        conclude();
    end
endmodule
